/* File: core/rf_tx_pkg.sv */
// constants, register map and carrier types of the radio tx timing block
// assumes one 100 mhz clock shared with the ahb-lite bus
package rf_tx_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_PERIOD_MS = 1;
  localparam int unsigned TICK_CYCLES =
    TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_W = 17;
  // --------------------------------------------------------------
  // widths
  // --------------------------------------------------------------
  localparam int SEED_W = 7;
  localparam int BASE_W = 8;
  localparam int FN_SET_W = 6;
  localparam int FRAME_W = 4;
  localparam int CNT_W = 10;
  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] SEED_CTRL_OFS = 8'h00;
  localparam logic [7:0] FRAME_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_CTRL_OFS = 8'h08;
  localparam logic [7:0] TX_CTRL_OFS = 8'h0c;
  localparam int BOOST_BIT = 7;
  localparam int GAIN_LSB = 6;
  localparam int DONE_BIT = 7;
  localparam int ERR_BIT = 6;
  localparam int LOW_BIT = 5;
  localparam int ACK_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int LVD_EN_BIT = 2;
  localparam int CTS_BIT = 1;
  localparam int SRST_BIT = 0;
  localparam int START_BIT = 8;
  localparam logic [1:0] GAIN_RST = 2'h2;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_req_t;
  typedef struct packed {
    logic done_ok;
    logic error;
    logic supply_low;
    logic tx_end;
    logic gap_start;
    logic osc_locked;
    logic buffer_mode;
    logic [FRAME_W-1:0] frame_index;
  } seq_status_t;
  typedef struct packed {
    logic tx_start;
    logic tx_abort;
    logic soft_reset;
    logic boost;
    logic [1:0] gain;
    logic lvd_enable;
    logic gap_active;
    logic gap_done;
  } seq_ctrl_t;
  typedef enum {ST_IDLE, ST_PAR, ST_BASE, ST_FNUM, ST_RAND} gap_state_t;
endpackage

/* File: core/seed_lfsr.sv */
// seven-bit pseudo-random generator with parallel seed load
// assumes load and step are never asserted together
module seed_lfsr
  import rf_tx_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic load,
  input wire logic [SEED_W-1:0] seed,
  input wire logic step,
  // state
  output logic [SEED_W-1:0] value
);
  // zero is a fixed point of this feedback, so an unseeded run stays zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      value <= '0;
    end else if (clear) begin
      value <= '0;
    end else if (load) begin
      value <= seed;
    end else if (step) begin
      value <= {value[SEED_W-2:0], value[SEED_W-1] ^ value[SEED_W-2]};
    end
  end
endmodule

/* File: core/interval_countdown.sv */
// millisecond down counter: loads a count, decrements once per tick
// assumes tick is a one-cycle pulse
module interval_countdown
  import rf_tx_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic clear,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic tick,
  // state
  output logic expired
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (load) begin
      count <= load_value;
    end else if (tick && count != '0) begin
      count <= count - CNT_W'(1);
    end
  end

  assign expired = (count == '0);
endmodule

/* File: core/rf_tx_frame_timing_status.sv */
// frame sequencer timing and status registers of the radio tx module
// assumes an ahb-lite master and a sequencer that reports frame events
// Function
// - soft reset zeroes random seed field
// - bit 7 boost selects vco power level
// - seed copied into lfsr when start set
// - nonzero seed enables random interval timing
// - random interval is one tick per count
// - all-zero lfsr state stays zero
// - zero seed: base and frame timers parallel
// - gain field bits 7:6, reset to 10
// - frame interval is setting times frame number
// - soft reset zeroes frame interval setting
// - completion flag on proper buffered end
// - error flag sticky until cleared
// - low supply flag sticky when detector enabled
// - ack one or soft reset clears flags
// - ack zero no effect, reset keeps ack
// - irq enable gates the three flags
// - detect enable bit routes supply events
// - clear to send follows lock, reset clears
// - soft reset bit resets module, reads zero
// - base setting is one tick per count
// - start bit self-clears, zero write aborts
//
// Added by the designer: the address map and the AHB-Lite slave port.
module rf_tx_frame_timing_status
  import rf_tx_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // sequencer side
  input wire seq_status_t seq,
  output seq_ctrl_t ctrl,
  output logic [SEED_W-1:0] lfsr_value,
  // interrupt
  output logic irq
);
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  bus_req_t req;
  logic rd_wait;
  logic [SEED_W-1:0] seed;
  logic boost;
  logic [1:0] gain;
  logic [FN_SET_W-1:0] fn_set;
  logic [BASE_W-1:0] base_set;
  logic done_flag, err_flag, low_flag;
  logic ack, irq_en, lvd_en, cts, soft_rst, tx_start;
  gap_state_t state;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic wr, seed_nz, start_set, a_load, a_exp, b_load, b_exp;
  logic lfsr_step, flag_clr, gap_done;
  logic [CNT_W-1:0] a_val, b_val;
  logic [7:0] status_rd;
  logic [31:0] next_rdata;

  // --------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------
  // reads take one wait state so a write just ahead is already visible
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;
  assign wr = req.valid && req.write;
  assign start_set = wr && req.addr == TX_CTRL_OFS && hwdata[START_BIT]
    && !tx_start;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
    end else if (hready) begin
      req.valid <= hsel && htrans[1];
      req.write <= hwrite;
      req.addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= hready && hsel && htrans[1] && !hwrite;
    end
  end

  // unmapped addresses read zero and ignore writes
  always_comb begin
    next_rdata = '0;
    case (req.addr)
      SEED_CTRL_OFS: next_rdata[7:0] = {boost, seed};
      FRAME_CTRL_OFS: next_rdata[7:0] = {gain, fn_set};
      STATUS_CTRL_OFS: next_rdata[7:0] = status_rd;
      TX_CTRL_OFS: next_rdata[START_BIT:0] = {tx_start, base_set};
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_wait) begin
      hrdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr && req.addr == STATUS_CTRL_OFS
        && hwdata[SRST_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seed <= '0;
      boost <= 1'b0;
    end else if (soft_rst) begin
      seed <= '0;
      boost <= 1'b0;
    end else if (wr && req.addr == SEED_CTRL_OFS) begin
      seed <= hwdata[SEED_W-1:0];
      boost <= hwdata[BOOST_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain <= GAIN_RST;
      fn_set <= '0;
    end else if (soft_rst) begin
      gain <= GAIN_RST;
      fn_set <= '0;
    end else if (wr && req.addr == FRAME_CTRL_OFS) begin
      gain <= hwdata[GAIN_LSB+1:GAIN_LSB];
      fn_set <= hwdata[FN_SET_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base_set <= '0;
    end else if (soft_rst) begin
      base_set <= '0;
    end else if (wr && req.addr == TX_CTRL_OFS) begin
      base_set <= hwdata[BASE_W-1:0];
    end
  end

  // start: set by software, cleared by end of frame, zero write aborts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_start <= 1'b0;
    end else if (soft_rst || seq.tx_end) begin
      tx_start <= 1'b0;
    end else if (wr && req.addr == TX_CTRL_OFS) begin
      tx_start <= hwdata[START_BIT];
    end
  end

  // ack is kept across soft reset; only a write changes it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack <= 1'b0;
    end else if (wr && req.addr == STATUS_CTRL_OFS) begin
      ack <= hwdata[ACK_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en <= 1'b0;
      lvd_en <= 1'b0;
    end else if (soft_rst) begin
      irq_en <= 1'b0;
      lvd_en <= 1'b0;
    end else if (wr && req.addr == STATUS_CTRL_OFS) begin
      irq_en <= hwdata[IRQ_EN_BIT];
      lvd_en <= hwdata[LVD_EN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cts <= 1'b0;
    end else begin
      cts <= !soft_rst && seq.osc_locked;
    end
  end

  // --------------------------------------------------------------
  // status flags
  // --------------------------------------------------------------
  // an event in the cycle of an ack still sets its flag
  assign flag_clr = soft_rst || (wr && req.addr == STATUS_CTRL_OFS
    && hwdata[ACK_BIT]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_flag <= 1'b0;
      err_flag <= 1'b0;
      low_flag <= 1'b0;
    end else begin
      done_flag <= (done_flag && !flag_clr)
        || (seq.done_ok && seq.buffer_mode && !soft_rst);
      err_flag <= (err_flag && !flag_clr)
        || (seq.error && !soft_rst);
      low_flag <= (low_flag && !flag_clr)
        || (seq.supply_low && lvd_en && !soft_rst);
    end
  end

  // completion reads zero while sending or outside buffer mode
  assign status_rd = {done_flag && !tx_start && seq.buffer_mode,
    err_flag, low_flag, ack, irq_en, lvd_en, cts, 1'b0};
  assign irq = irq_en && (done_flag || err_flag || low_flag);

  // --------------------------------------------------------------
  // interval timing
  // --------------------------------------------------------------
  // the tick is free running, so each interval is nominal within one tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end
  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES_P - 1));

  assign seed_nz = |seed;
  assign lfsr_step = (state == ST_FNUM) && a_exp;

  seed_lfsr u_lfsr (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(soft_rst),
    .load(start_set),
    .seed(seed),
    .step(lfsr_step),
    .value(lfsr_value)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
    end else if (soft_rst || !tx_start) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (seq.gap_start) begin
            state <= seed_nz ? ST_BASE : ST_PAR;
          end
        end
        ST_PAR: begin
          if (a_exp && b_exp) begin
            state <= ST_IDLE;
          end
        end
        ST_BASE: begin
          if (a_exp) begin
            state <= ST_FNUM;
          end
        end
        ST_FNUM: begin
          if (a_exp) begin
            state <= ST_RAND;
          end
        end
        ST_RAND: begin
          if (a_exp) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // counter a walks base, frame and random stages; b runs beside a only for a zero seed
  always_comb begin
    a_load = 1'b0;
    a_val = CNT_W'(base_set);
    if (state == ST_IDLE && seq.gap_start) begin
      a_load = 1'b1;
    end else if (state == ST_BASE && a_exp) begin
      a_load = 1'b1;
      a_val = CNT_W'(fn_set * seq.frame_index);
    end else if (state == ST_FNUM && a_exp) begin
      a_load = 1'b1;
      a_val = CNT_W'(lfsr_value);
    end
  end
  assign b_load = state == ST_IDLE && seq.gap_start && !seed_nz;
  assign b_val = CNT_W'(fn_set * seq.frame_index);

  interval_countdown u_cnt_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(soft_rst),
    .load(a_load),
    .load_value(a_val),
    .tick(tick),
    .expired(a_exp)
  );

  interval_countdown u_cnt_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(soft_rst),
    .load(b_load),
    .load_value(b_val),
    .tick(tick),
    .expired(b_exp)
  );

  assign gap_done = tx_start && ((state == ST_PAR && a_exp && b_exp)
    || (state == ST_RAND && a_exp));

  always_comb begin
    ctrl.tx_start = tx_start;
    ctrl.tx_abort = wr && req.addr == TX_CTRL_OFS && !hwdata[START_BIT]
      && tx_start;
    ctrl.soft_reset = soft_rst;
    ctrl.boost = boost;
    ctrl.gain = gain;
    ctrl.lvd_enable = lvd_en;
    ctrl.gap_active = state != ST_IDLE;
    ctrl.gap_done = gap_done;
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_soft_write;
    wr && req.addr == STATUS_CTRL_OFS && hwdata[SRST_BIT];
  endsequence
  sequence s_soft_applied;
    ##1 soft_rst ##1 (seed == '0 && !boost && fn_set == '0);
  endsequence

  property p_soft_reset;
    s_soft_write |-> s_soft_applied;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset left settings");

  property p_gain_reset;
    soft_rst |=> gain == GAIN_RST && !irq_en && !lvd_en && !cts;
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("soft reset left gain or enables");

  property p_seed_load;
    start_set && !soft_rst |=> lfsr_value == $past(seed);
  endproperty
  a_seed_load: assert property (p_seed_load)
    else $error("seed not copied at start");

  property p_lfsr_zero;
    lfsr_value == '0 && !start_set |=> lfsr_value == '0;
  endproperty
  a_lfsr_zero: assert property (p_lfsr_zero)
    else $error("zero lfsr left zero state");

  property p_parallel;
    state == ST_IDLE && tx_start && !soft_rst && seq.gap_start
      && !seed_nz |=> state == ST_PAR || !tx_start;
  endproperty
  a_parallel: assert property (p_parallel)
    else $error("zero seed did not run timers together");

  property p_ack_kept;
    soft_rst |=> ack == $past(ack);
  endproperty
  a_ack_kept: assert property (p_ack_kept)
    else $error("soft reset changed ack");

  property p_flag_clear;
    flag_clr && !seq.done_ok && !seq.error && !seq.supply_low
      |=> !done_flag && !err_flag && !low_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("ack left a flag set");

  property p_err_sticky;
    err_flag && !flag_clr |=> err_flag;
  endproperty
  a_err_sticky: assert property (p_err_sticky)
    else $error("error flag dropped");

  property p_low_cause;
    $rose(low_flag) |-> $past(lvd_en) && $past(seq.supply_low);
  endproperty
  a_low_cause: assert property (p_low_cause)
    else $error("low flag set without enabled detector");

  property p_done_hidden;
    tx_start |-> !status_rd[DONE_BIT];
  endproperty
  a_done_hidden: assert property (p_done_hidden)
    else $error("completion visible while sending");

  property p_irq;
    irq_en && !soft_rst && !(wr && req.addr == STATUS_CTRL_OFS)
      && (seq.error || (seq.done_ok && seq.buffer_mode)) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq missing after flag event");

  property p_cts;
    cts |-> $past(seq.osc_locked) && !$past(soft_rst);
  endproperty
  a_cts: assert property (p_cts)
    else $error("clear to send without lock");
endmodule

/* File: verification/seq_partner.sv */
// far-side sequencer model: answers each start with one interval
// assumes the bench steers the error, supply, lock and frame knobs
module seq_partner
  import rf_tx_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // block side
  input wire seq_ctrl_t ctrl,
  output seq_status_t seq,
  // bench knobs
  input wire logic fail_next,
  input wire logic supply_low,
  input wire logic locked,
  input wire logic buffer_mode,
  input wire logic [FRAME_W-1:0] frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  logic start_q;
  logic gap;
  logic ended;
  logic ok;
  logic err;
  assign seq = {ok, err, supply_low, ended, gap, locked, buffer_mode, frame};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      start_q <= 1'b0;
      gap <= 1'b0;
      ended <= 1'b0;
      ok <= 1'b0;
      err <= 1'b0;
    end else begin
      start_q <= ctrl.tx_start;
      gap <= 1'b0;
      ended <= 1'b0;
      ok <= 1'b0;
      err <= 1'b0;
      // an abort leaves no frame end behind
      if (ctrl.tx_abort || ctrl.soft_reset) begin
        busy <= 1'b0;
      end else if (!busy && ctrl.tx_start && !start_q) begin
        busy <= 1'b1;
        gap <= 1'b1;
      end else if (busy && ctrl.gap_done) begin
        busy <= 1'b0;
        ended <= 1'b1;
        ok <= !fail_next;
        err <= fail_next;
      end
    end
  end
endmodule

/* File: verification/test_rf_tx_frame_timing_status.sv */
// self-checking bench of the radio tx timing and status block
// assumes one ahb-lite master, the sequencer model and a 10-cycle tick
module test_rf_tx_frame_timing_status
  import rf_tx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 10;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic buf_mode = 1'b1;
  logic fail_next = 1'b0;
  logic low = 1'b0;
  logic locked = 1'b0;
  logic [FRAME_W-1:0] frame = 4'h3;
  seq_status_t seq;
  seq_ctrl_t ctrl;
  logic [SEED_W-1:0] lfsr_value;
  int n_fail = 0;
  int checks_done = 0;

  initial forever #5 hclk = ~hclk;

  rf_tx_frame_timing_status #(.TICK_CYCLES_P(TK)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .seq(seq),
    .ctrl(ctrl), .lfsr_value(lfsr_value), .irq(irq));

  seq_partner model (.hclk(hclk), .hresetn(hresetn), .ctrl(ctrl),
    .seq(seq), .fail_next(fail_next), .supply_low(low), .locked(locked),
    .buffer_mode(buf_mode), .frame(frame));

  // ------------------------------------------------------------
  // reporting and bus tasks
  // ------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int exp, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      n_fail++;
      $display("[ERR] %0t interval %0d ticks, expected %0d", $time, got,
        exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // ready is settled by the falling edge, so it is read there
  task automatic wait_rdy();
    int n;
    logic r;
    n = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      @(posedge hclk);
      n++;
    end while (r !== 1'b1 && n < 50);
    if (r !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t bus hang", $time);
      final_report();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  // start one frame and time its interval in ticks
  task automatic run_tx(input logic [7:0] base, input int exp,
                        input int tol, input logic [6:0] seed);
    int n;
    wr(TX_CTRL_OFS, {23'h0, 1'b1, base});
    cyc(2);
    chk({25'h0, lfsr_value}, {25'h0, seed});
    n = 0;
    while (ctrl.gap_done !== 1'b1 && n < 3000) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 3000) begin
      n_fail++;
      $display("[ERR] %0t interval never ended", $time);
      final_report();
    end
    chk_rng(n / TK, exp, tol);
    @(posedge hclk);
    cyc(5);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    rdchk(SEED_CTRL_OFS, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({30'h0, ctrl.gain}, 32'h2);
    rdchk(FRAME_CTRL_OFS, 32'h80);
    rdchk(STATUS_CTRL_OFS, 32'h0);
    rdchk(TX_CTRL_OFS, 32'h0);
    wr(8'h10, 32'hff);
    rdchk(8'h10, 32'h0);
    wr(SEED_CTRL_OFS, 32'hff);
    rdchk(SEED_CTRL_OFS, 32'hff);
    chk({31'h0, ctrl.boost}, 32'h1);
    wr(FRAME_CTRL_OFS, 32'h7f);
    rdchk(FRAME_CTRL_OFS, 32'h7f);
    chk({30'h0, ctrl.gain}, 32'h1);
    wr(STATUS_CTRL_OFS, 32'he0);
    rdchk(STATUS_CTRL_OFS, 32'h0);
  endtask

  task automatic s_parallel();
    locked <= 1'b1;
    cyc(3);
    rdchk(STATUS_CTRL_OFS, 32'h02);
    wr(SEED_CTRL_OFS, 32'h00);
    wr(FRAME_CTRL_OFS, 32'h82);
    wr(STATUS_CTRL_OFS, 32'h08);
    run_tx(8'h05, 6, 1, 7'h00);
    chk({31'h0, irq}, 32'h1);
    chk({25'h0, lfsr_value}, 32'h0);
    rdchk(STATUS_CTRL_OFS, 32'h8a);
    rdchk(TX_CTRL_OFS, 32'h05);
    wr(STATUS_CTRL_OFS, 32'h18);
    rdchk(STATUS_CTRL_OFS, 32'h1a);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic s_serial();
    wr(FRAME_CTRL_OFS, 32'h80);
    wr(SEED_CTRL_OFS, 32'h03);
    wr(STATUS_CTRL_OFS, 32'h08);
    run_tx(8'h05, 8, 2, 7'h03);
    rdchk(SEED_CTRL_OFS, 32'h03);
  endtask

  task automatic s_error();
    fail_next <= 1'b1;
    run_tx(8'h05, 8, 2, 7'h03);
    fail_next <= 1'b0;
    rdchk(STATUS_CTRL_OFS, 32'hca);
    buf_mode <= 1'b0;
    rdchk(STATUS_CTRL_OFS, 32'h4a);
    buf_mode <= 1'b1;
    chk({31'h0, irq}, 32'h1);
    wr(STATUS_CTRL_OFS, 32'h08);
    rdchk(STATUS_CTRL_OFS, 32'hca);
    wr(STATUS_CTRL_OFS, 32'h18);
    rdchk(STATUS_CTRL_OFS, 32'h1a);
  endtask

  task automatic s_low();
    wr(STATUS_CTRL_OFS, 32'h00);
    low <= 1'b1;
    cyc(4);
    rdchk(STATUS_CTRL_OFS, 32'h02);
    wr(STATUS_CTRL_OFS, 32'h04);
    cyc(2);
    chk({31'h0, ctrl.lvd_enable}, 32'h1);
    low <= 1'b0;
    cyc(2);
    rdchk(STATUS_CTRL_OFS, 32'h26);
    chk({31'h0, irq}, 32'h0);
  endtask

  // a clean end outside buffer mode must not raise completion
  task automatic s_nobuf();
    buf_mode <= 1'b0;
    run_tx(8'h05, 8, 2, 7'h03);
    buf_mode <= 1'b1;
    rdchk(STATUS_CTRL_OFS, 32'h26);
  endtask

  task automatic s_abort();
    wr(TX_CTRL_OFS, 32'h114);
    cyc(10);
    chk({31'h0, ctrl.gap_active}, 32'h1);
    wr(TX_CTRL_OFS, 32'h014);
    rdchk(TX_CTRL_OFS, 32'h14);
    chk({31'h0, ctrl.gap_active}, 32'h0);
    cyc(300);
    rdchk(STATUS_CTRL_OFS, 32'h26);
  endtask

  task automatic s_soft();
    wr(SEED_CTRL_OFS, 32'hff);
    wr(FRAME_CTRL_OFS, 32'hff);
    locked <= 1'b0;
    wr(STATUS_CTRL_OFS, 32'h0d);
    cyc(3);
    rdchk(SEED_CTRL_OFS, 32'h0);
    rdchk(FRAME_CTRL_OFS, 32'h80);
    rdchk(STATUS_CTRL_OFS, 32'h0);
    rdchk(TX_CTRL_OFS, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_parallel();
    s_serial();
    s_error();
    s_low();
    s_nobuf();
    s_abort();
    s_soft();
    final_report();
  end
endmodule
